//--- ptp_message_config_map.vh
`ifndef PTP_MESSAGE_CONFIG_MAP_VH
`define PTP_MESSAGE_CONFIG_MAP_VH

// Register byte offsets
`define CFG_ONE_ADDR      16'h0514
`define CFG_TWO_ADDR      16'h0516

// First configuration register fields
`define CFG1_AS_MODE      7
`define CFG1_PTP_EN       6
`define CFG1_DET_ETH      5
`define CFG1_DET_IPV4     4
`define CFG1_DET_IPV6     3
`define CFG1_P2P          2
`define CFG1_MASTER       1
`define CFG1_ONE_STEP     0
`define CFG1_WMASK        16'h00FF
`define CFG1_RESET        16'h0039

// Second configuration register fields
`define CFG2_UNICAST      12
`define CFG2_ALT_MASTER   11
`define CFG2_PRIO_ALL     10
`define CFG2_SYNC_ASSOC   9
`define CFG2_WMASK        16'h1E00
`define CFG2_RESET        16'h1000

// Protocol constants
`define UDP_EVENT_PORT    16'h013F
`define UDP_GENERAL_PORT  16'h0140
`define MSG_SYNC          4'h0
`define MSG_DELAY_REQ     4'h1
`define MSG_FOLLOW_UP     4'h8
`define MSG_EVENT_LIMIT   4'h8

// Sync record memory
`define SYNC_IDX_W        4
`define SYNC_DEPTH        16
`define SYNC_REC_W        40

// Decision word layout
`define DEC_W             6
`define DEC_IS_PTP        5
`define DEC_TO_HOST       4
`define DEC_TO_NONHOST    3
`define DEC_LOOKUP        2
`define DEC_HIGH_PRIO     1
`define DEC_MAY_MODIFY    0

`endif

//--- sync_record_mem.v
`timescale 1ns/10ps
`include "ptp_message_config_map.vh"

module sync_record_mem (
  // Clock and reset
  input  wire                     mclk,
  input  wire                     sys_rst,
  // Write side
  input  wire                     wrEn,
  input  wire [`SYNC_IDX_W-1:0]   wrIdx,
  input  wire [`SYNC_REC_W-1:0]   wrData,
  // Read side
  input  wire                     rdEn,
  input  wire [`SYNC_IDX_W-1:0]   rdIdx,
  output reg                      rdHit_q,
  output reg  [`SYNC_REC_W-1:0]   rdData_q
);

  reg [`SYNC_REC_W-1:0] mem [0:`SYNC_DEPTH-1];
  reg [`SYNC_DEPTH-1:0] entValid_q;

  // Storage, written entries become valid
  always @(posedge mclk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      entValid_q <= {`SYNC_DEPTH{1'b0}};
    end else if (wrEn) begin
      entValid_q[wrIdx] <= 1'b1;
    end
  end

  // Registered read, write data bypassed on same index
  always @(posedge mclk) begin
    if (sys_rst) begin
      rdHit_q  <= 1'b0;
      rdData_q <= {`SYNC_REC_W{1'b0}};
    end else if (rdEn) begin
      if (wrEn && (wrIdx == rdIdx)) begin
        rdHit_q  <= 1'b1;
        rdData_q <= wrData;
      end else begin
        rdHit_q  <= entValid_q[rdIdx];
        rdData_q <= mem[rdIdx];
      end
    end
  end

endmodule // sync_record_mem

//--- two_entry_buffer.v
`timescale 1ns/10ps

module two_entry_buffer #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         sys_rst,
  // Fill side
  input  wire         inValid,
  output wire         inReady,
  input  wire [W-1:0] inData,
  // Drain side
  output reg          outValid_q,
  input  wire         outReady,
  output reg  [W-1:0] outData_q
);

  reg         skidValid_q;
  reg [W-1:0] skidData_q;
  wire        push;
  wire        pop;

  assign inReady = ~skidValid_q;
  assign push    = inValid & ~skidValid_q;
  assign pop     = outValid_q & outReady;

  // Head register plus one skid entry
  always @(posedge mclk) begin
    if (sys_rst) begin
      outValid_q  <= 1'b0;
      outData_q   <= {W{1'b0}};
      skidValid_q <= 1'b0;
      skidData_q  <= {W{1'b0}};
    end else if (!outValid_q || pop) begin
      if (skidValid_q) begin
        outValid_q  <= 1'b1;
        outData_q   <= skidData_q;
        skidValid_q <= 1'b0;
      end else begin
        outValid_q <= push;
        if (push) begin
          outData_q <= inData;
        end
      end
    end else if (push) begin
      skidValid_q <= 1'b1;
      skidData_q  <= inData;
    end
  end

endmodule // two_entry_buffer

//--- ptp_message_config.v
// Function
// - Bridging mode needs protocol mode enabled
// - Bridging mode: all but unicast to host, unmodified
// - Protocol mode classifies messages specially
// - Protocol mode runs clock, may modify
// - Protocol mode uses timestamp tail tags
// - Ethernet detection gated by bit 5
// - IPv4/UDP detection gated by bit 4
// - IPv6/UDP detection gated by bit 3
// - Bit 2 selects peer or end
// - Bit 1 selects host master or slave
// - Bit 0 selects one or two step
// - Unicast on ports 319/320 uses lookup
// - Unicast off: only multicast recognised
// - Alternate master on: forward to non-host
// - Alternate master off: drop at host
// - Bit 10 puts all in top queue
// - Follow_Up to host only on Sync match
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "ptp_message_config_map.vh"

module ptp_message_config (
  // Clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // Register port
  input  wire [15:0] regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWrEn,
  input  wire        regRdEn,
  output reg  [15:0] regRdData_q,
  // Frame descriptor from parser
  input  wire        descValid,
  output reg         descReady_q,
  input  wire        descEthPtp,
  input  wire        descIpv4Udp,
  input  wire        descIpv6Udp,
  input  wire [15:0] descUdpDstPort,
  input  wire        descReservedAddr,
  input  wire [3:0]  descMsgType,
  input  wire [7:0]  descDomain,
  input  wire [15:0] descSeqId,
  input  wire [15:0] descSrcPort,
  input  wire        descFromHost,
  input  wire        descFromActiveMaster,
  input  wire [7:0]  localDomain,
  // Forwarding decision
  output wire        decValid,
  input  wire        decReady,
  output wire        decIsPtp,
  output wire        decToHost,
  output wire        decToNonHost,
  output wire        decUseLookup,
  output wire        decHighPrio,
  output wire        decMayModify,
  // Mode outputs to switch core
  output reg         ptpClockRun_q,
  output reg         tailTagStamp_q,
  output reg         bridgeMode_q,
  output reg         peerToPeer_q,
  output reg         hostMaster_q,
  output reg         oneStep_q
);

  // Message type decode
  function typeIs;
    input [3:0] msgType;
    input [3:0] code;
    begin
      typeIs = (msgType == code);
    end
  endfunction

  function udpPortHit;
    input [15:0] port;
    begin
      udpPortHit = (port == `UDP_EVENT_PORT) || (port == `UDP_GENERAL_PORT);
    end
  endfunction

  function isEventMsg;
    input [3:0] msgType;
    begin
      isEventMsg = (msgType < `MSG_EVENT_LIMIT);
    end
  endfunction

  // Register address decode
  function isCfgOne;
    input [15:0] addr;
    begin
      isCfgOne = (addr == `CFG_ONE_ADDR);
    end
  endfunction

  function isCfgTwo;
    input [15:0] addr;
    begin
      isCfgTwo = (addr == `CFG_TWO_ADDR);
    end
  endfunction

  // Bridging mode only counts with protocol mode
  function bridgeActive;
    input [15:0] cfg;
    begin
      bridgeActive = cfg[`CFG1_AS_MODE] & cfg[`CFG1_PTP_EN];
    end
  endfunction

  // Configuration registers
  reg  [15:0] cfgOne_q;
  reg  [15:0] cfgTwo_q;
  reg  [15:0] regRdData_d;

  // Stage one: captured descriptor and config snapshot
  reg         s1Valid_q;
  reg         s1Valid_d;
  reg         s1Eth_q;
  reg         s1V4_q;
  reg         s1V6_q;
  reg         s1PortHit_q;
  reg         s1Reserved_q;
  reg  [3:0]  s1Type_q;
  reg  [7:0]  s1Domain_q;
  reg  [15:0] s1Seq_q;
  reg  [15:0] s1Src_q;
  reg         s1FromHost_q;
  reg         s1FromMaster_q;
  reg  [7:0]  s1LocalDomain_q;
  reg  [15:0] s1CfgOne_q;
  reg  [15:0] s1CfgTwo_q;

  // Decision terms
  reg         asMode;
  reg         encapOk;
  reg         unicast;
  reg         isPtp;
  reg         toHost;
  reg         toNonHost;
  reg         useLookup;
  reg         highPrio;
  reg         mayModify;
  reg         syncMatch;
  reg         masterSyncLike;

  wire        accept;
  wire        advance;
  wire        bufInReady;
  wire        recWrEn;
  wire        recHit;
  wire [`SYNC_REC_W-1:0] recRdData;
  wire [`DEC_W-1:0]      decWord;
  wire [`DEC_W-1:0]      bufOut;

  assign accept  = descValid & descReady_q;
  assign advance = s1Valid_q & bufInReady;

  // Register writes, reserved bits stay zero
  always @(posedge mclk) begin
    if (sys_rst) begin
      cfgOne_q <= `CFG1_RESET;
      cfgTwo_q <= `CFG2_RESET;
    end else if (regWrEn) begin
      if (isCfgOne(regAddr)) begin
        cfgOne_q <= regWrData & `CFG1_WMASK;
      end
      if (isCfgTwo(regAddr)) begin
        cfgTwo_q <= regWrData & `CFG2_WMASK;
      end
    end
  end

  // Read data one cycle after strobe, zero elsewhere
  always @* begin
    regRdData_d = 16'h0000;
    if (regRdEn) begin
      if (isCfgOne(regAddr)) begin
        regRdData_d = cfgOne_q;
      end else if (isCfgTwo(regAddr)) begin
        regRdData_d = cfgTwo_q;
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      regRdData_q <= 16'h0000;
    end else begin
      regRdData_q <= regRdData_d;
    end
  end

  // Mode outputs
  always @(posedge mclk) begin
    if (sys_rst) begin
      ptpClockRun_q  <= 1'b0;
      tailTagStamp_q <= 1'b0;
      bridgeMode_q   <= 1'b0;
      peerToPeer_q   <= 1'b0;
      hostMaster_q   <= 1'b0;
      oneStep_q      <= 1'b1;
    end else begin
      ptpClockRun_q  <= cfgOne_q[`CFG1_PTP_EN];
      tailTagStamp_q <= cfgOne_q[`CFG1_PTP_EN];
      bridgeMode_q   <= bridgeActive(cfgOne_q);
      peerToPeer_q   <= cfgOne_q[`CFG1_P2P];
      hostMaster_q   <= cfgOne_q[`CFG1_MASTER];
      oneStep_q      <= cfgOne_q[`CFG1_ONE_STEP];
    end
  end

  // Stage one capture with configuration snapshot
  always @* begin
    s1Valid_d = s1Valid_q;
    if (advance) begin
      s1Valid_d = 1'b0;
    end
    if (accept) begin
      s1Valid_d = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      s1Valid_q   <= 1'b0;
      descReady_q <= 1'b0;
    end else begin
      s1Valid_q   <= s1Valid_d;
      descReady_q <= ~s1Valid_d;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      s1Eth_q         <= 1'b0;
      s1V4_q          <= 1'b0;
      s1V6_q          <= 1'b0;
      s1PortHit_q     <= 1'b0;
      s1Reserved_q    <= 1'b0;
      s1Type_q        <= 4'h0;
      s1Domain_q      <= 8'h00;
      s1Seq_q         <= 16'h0000;
      s1Src_q         <= 16'h0000;
      s1FromHost_q    <= 1'b0;
      s1FromMaster_q  <= 1'b0;
      s1LocalDomain_q <= 8'h00;
      s1CfgOne_q      <= `CFG1_RESET;
      s1CfgTwo_q      <= `CFG2_RESET;
    end else if (accept) begin
      s1Eth_q         <= descEthPtp;
      s1V4_q          <= descIpv4Udp;
      s1V6_q          <= descIpv6Udp;
      s1PortHit_q     <= udpPortHit(descUdpDstPort);
      s1Reserved_q    <= descReservedAddr;
      s1Type_q        <= descMsgType;
      s1Domain_q      <= descDomain;
      s1Seq_q         <= descSeqId;
      s1Src_q         <= descSrcPort;
      s1FromHost_q    <= descFromHost;
      s1FromMaster_q  <= descFromActiveMaster;
      s1LocalDomain_q <= localDomain;
      s1CfgOne_q      <= cfgOne_q;
      s1CfgTwo_q      <= cfgTwo_q;
    end
  end

  // Sync records keyed by source port
  assign recWrEn = advance & isPtp & typeIs(s1Type_q, `MSG_SYNC);

  sync_record_mem u_sync_mem (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .wrEn     (recWrEn),
    .wrIdx    (s1Src_q[`SYNC_IDX_W-1:0]),
    .wrData   ({s1Domain_q, s1Seq_q, s1Src_q}),
    .rdEn     (accept),
    .rdIdx    (descSrcPort[`SYNC_IDX_W-1:0]),
    .rdHit_q  (recHit),
    .rdData_q (recRdData)
  );

  // Classification and forwarding decision
  always @* begin
    asMode = bridgeActive(s1CfgOne_q);
    encapOk = (s1Eth_q & s1CfgOne_q[`CFG1_DET_ETH])
            | (s1V4_q & s1CfgOne_q[`CFG1_DET_IPV4])
            | (s1V6_q & s1CfgOne_q[`CFG1_DET_IPV6]);
    unicast = s1CfgTwo_q[`CFG2_UNICAST] & (s1V4_q | s1V6_q)
            & s1PortHit_q & ~s1Reserved_q;
    isPtp = s1CfgOne_q[`CFG1_PTP_EN] & encapOk & (s1Reserved_q | unicast);
    syncMatch = recHit && (recRdData == {s1Domain_q, s1Seq_q, s1Src_q});
    masterSyncLike = (typeIs(s1Type_q, `MSG_SYNC) || typeIs(s1Type_q, `MSG_DELAY_REQ))
                   && !s1FromHost_q && s1FromMaster_q;
    toHost    = 1'b0;
    toNonHost = 1'b0;
    useLookup = 1'b0;
    if (!isPtp) begin
      useLookup = 1'b1;
    end else if (unicast) begin
      useLookup = 1'b1;
    end else if (asMode) begin
      toHost = 1'b1;
    end else if (s1FromHost_q) begin
      toNonHost = 1'b1;
    end else if (masterSyncLike) begin
      if (s1Domain_q != s1LocalDomain_q) begin
        toNonHost = 1'b1;
      end else if (s1CfgTwo_q[`CFG2_ALT_MASTER]) begin
        toNonHost = 1'b1;
      end else begin
        toNonHost = 1'b0;
      end
    end else if (typeIs(s1Type_q, `MSG_FOLLOW_UP) && s1CfgTwo_q[`CFG2_SYNC_ASSOC]) begin
      toHost = syncMatch;
    end else begin
      toHost = 1'b1;
    end
    highPrio = isPtp & (s1CfgTwo_q[`CFG2_PRIO_ALL]
             | isEventMsg(s1Type_q));
    mayModify = isPtp & ~asMode;
  end

  assign decWord = {isPtp, toHost, toNonHost, useLookup, highPrio, mayModify};

  // Output buffer holds decisions while receiver stalls
  two_entry_buffer #(
    .W (`DEC_W)
  ) u_dec_buf (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .inValid    (s1Valid_q),
    .inReady    (bufInReady),
    .inData     (decWord),
    .outValid_q (decValid),
    .outReady   (decReady),
    .outData_q  (bufOut)
  );

  assign decIsPtp     = bufOut[`DEC_IS_PTP];
  assign decToHost    = bufOut[`DEC_TO_HOST];
  assign decToNonHost = bufOut[`DEC_TO_NONHOST];
  assign decUseLookup = bufOut[`DEC_LOOKUP];
  assign decHighPrio  = bufOut[`DEC_HIGH_PRIO];
  assign decMayModify = bufOut[`DEC_MAY_MODIFY];

endmodule // ptp_message_config

//--- ptp_cfg_monitor.sv
`timescale 1ns/10ps
module ptp_cfg_monitor (
  // Clock and reset
  input logic        mclk,
  input logic        sys_rst,
  // Register port
  input logic [15:0] regAddr,
  input logic [15:0] regWrData,
  input logic        regWrEn,
  input logic        regRdEn,
  input logic [15:0] regRdData_q,
  // Descriptor and decision
  input logic        descValid,
  input logic        descReady_q,
  input logic        decValid,
  input logic        decReady,
  input logic        decIsPtp,
  input logic        decToHost,
  input logic        decToNonHost,
  input logic        decUseLookup,
  input logic        decHighPrio,
  input logic        decMayModify,
  // Mode outputs
  input logic        ptpClockRun_q,
  input logic        tailTagStamp_q,
  input logic        bridgeMode_q,
  input logic        peerToPeer_q,
  input logic        hostMaster_q,
  input logic        oneStep_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_mode_bits:
    assert property (regWrEn && regAddr == 16'h0514 |-> ##2 oneStep_q == $past(regWrData[0], 2)
      && hostMaster_q == $past(regWrData[1], 2) && peerToPeer_q == $past(regWrData[2], 2))
      else $error("mode outputs differ from write");
  a_bridge_gate:
    assert property (regWrEn && regAddr == 16'h0514 |-> ##2
      bridgeMode_q == ($past(regWrData[7], 2) && $past(regWrData[6], 2)))
      else $error("bridge mode without protocol mode");
  a_clock_stamp:
    assert property (ptpClockRun_q == tailTagStamp_q && (tailTagStamp_q || !bridgeMode_q))
      else $error("clock run and tail tag disagree");
  a_rd_unmapped:
    assert property (regRdEn && regAddr != 16'h0514 && regAddr != 16'h0516
      |=> regRdData_q == 16'h0000) else $error("unmapped read not zero");
  a_ready_drop:
    assert property (descValid && descReady_q |=> !descReady_q)
      else $error("ready stayed high after take");
  a_dec_hold:
    assert property (decValid && !decReady |=> decValid && $stable({decIsPtp, decToHost,
      decToNonHost, decUseLookup, decHighPrio, decMayModify}))
      else $error("decision changed before take");
  a_nonptp_lookup:
    assert property (decValid && !decIsPtp |-> decUseLookup && !decHighPrio
      && !decToHost && !decToNonHost) else $error("plain frame not by lookup");
  a_unicast_only:
    assert property (decValid && decIsPtp && decUseLookup |-> !decToHost && !decToNonHost)
      else $error("unicast frame also forced");
endmodule // ptp_cfg_monitor

bind ptp_message_config ptp_cfg_monitor i_mon (.mclk, .sys_rst, .regAddr, .regWrData,
  .regWrEn, .regRdEn, .regRdData_q, .descValid, .descReady_q, .decValid, .decReady,
  .decIsPtp, .decToHost, .decToNonHost, .decUseLookup, .decHighPrio, .decMayModify,
  .ptpClockRun_q, .tailTagStamp_q, .bridgeMode_q, .peerToPeer_q, .hostMaster_q, .oneStep_q);

//--- dec_sink.sv
`timescale 1ns/10ps
module dec_sink (
  // Clock and reset
  input  logic       mclk,
  input  logic       sys_rst,
  // Decision side
  input  logic       decValid,
  output logic       decReady,
  input  logic [5:0] decFlags,
  // Control and log
  input  logic [1:0] mode,
  output logic [7:0] count
);
  logic [5:0] logDec [0:31];
  logic       phase_q;
  always @(posedge mclk) begin
    if (sys_rst) begin
      count <= 8'h00;
      phase_q <= 1'b0;
      decReady <= 1'b0;
    end else begin
      phase_q <= !phase_q;
      // Prompt, every other cycle, or stalled
      decReady <= (mode == 2'd0) || (mode == 2'd1 && phase_q);
      if (decValid && decReady) begin
        logDec[count[4:0]] <= decFlags;
        count <= count + 8'h01;
      end
    end
  end
endmodule // dec_sink

//--- ptp_message_config_bench.sv
`timescale 1ns/10ps
module ptp_message_config_bench;
  localparam logic [5:0] NOMOD = 6'h3E;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] regAddr = 16'h0000, regWrData = 16'h0000, regRdData_q;
  logic [15:0] descUdpDstPort = 16'h0000, descSeqId = 16'h0000;
  logic regWrEn = 1'b0, regRdEn = 1'b0, descValid = 1'b0, descReady_q;
  logic descEthPtp = 1'b0, descIpv4Udp = 1'b0, descIpv6Udp = 1'b0, descReservedAddr = 1'b0;
  logic descFromHost = 1'b0, descFromActiveMaster = 1'b0, decReady, decValid;
  logic [3:0] descMsgType = 4'h0;
  logic [7:0] descDomain = 8'h00, localDomain = 8'h00;
  logic [1:0] sinkMode = 2'd0;
  logic decIsPtp, decToHost, decToNonHost, decUseLookup, decHighPrio, decMayModify;
  logic ptpClockRun_q, tailTagStamp_q, bridgeMode_q, peerToPeer_q, hostMaster_q, oneStep_q;
  int mismatches = 0;
  int num_checks = 0;
  int decIdx = 0;

  always #2.5 mclk = ~mclk;

  ptp_message_config i_dut (.mclk, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData_q, .descValid, .descReady_q, .descEthPtp, .descIpv4Udp, .descIpv6Udp,
    .descUdpDstPort, .descReservedAddr, .descMsgType, .descDomain, .descSeqId,
    .descSrcPort(descSeqId), .descFromHost, .descFromActiveMaster, .localDomain, .decValid,
    .decReady, .decIsPtp, .decToHost, .decToNonHost, .decUseLookup, .decHighPrio,
    .decMayModify, .ptpClockRun_q, .tailTagStamp_q, .bridgeMode_q, .peerToPeer_q,
    .hostMaster_q, .oneStep_q);

  dec_sink i_sink (.mclk, .sys_rst, .decValid, .decReady, .decFlags({decIsPtp, decToHost,
    decToNonHost, decUseLookup, decHighPrio, decMayModify}), .mode(sinkMode), .count());

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkDec(input logic [5:0] got, input logic [5:0] exp, input logic [5:0] m);
    check({10'h000, got & m}, {10'h000, exp & m});
  endtask

  task automatic stopIf(input bit hit);
    if (hit) begin
      mismatches++;
      $display("timeout at %0t", $time);
      complete_run();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    @(negedge mclk);
    check(regRdData_q, e);
  endtask

  task automatic send(input logic [2:0] enc, input logic rsv, input logic [15:0] pt,
                      input logic [3:0] mt, input logic [7:0] dom, input logic [15:0] seq,
                      input logic [1:0] src);
    int n;
    n = 0;
    @(posedge mclk);
    {descEthPtp, descIpv4Udp, descIpv6Udp} <= enc;
    descReservedAddr <= rsv;
    descUdpDstPort <= pt;
    descMsgType <= mt;
    descDomain <= dom;
    descSeqId <= seq;
    {descFromHost, descFromActiveMaster} <= src;
    descValid <= 1'b1;
    @(negedge mclk);
    while (descReady_q !== 1'b1 && n < 40) begin
      n++;
      @(negedge mclk);
    end
    stopIf(n == 40);
    @(posedge mclk);
    descValid <= 1'b0;
  endtask

  task automatic expDec(input logic [5:0] e, input logic [5:0] m);
    int n;
    n = 0;
    while (i_sink.count <= decIdx && n < 60) begin
      n++;
      @(negedge mclk);
    end
    stopIf(n == 60);
    checkDec(i_sink.logDec[decIdx % 32], e, m);
    decIdx++;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(16'h0514, 16'h0039);
    rd(16'h0516, 16'h1000);
    rd(16'h0518, 16'h0000);
    check({13'h0000, peerToPeer_q, hostMaster_q, oneStep_q}, 16'h0001);
    send(3'b100, 1'b1, 16'h0000, 4'h0, 8'h00, 16'h0001, 2'b00);
    expDec(6'b000100, NOMOD);
    $display("test reset done");
    wr(16'h0514, 16'hFFC6);
    rd(16'h0514, 16'h00C6);
    check({10'h000, bridgeMode_q, ptpClockRun_q, tailTagStamp_q, peerToPeer_q,
           hostMaster_q, oneStep_q}, 16'h003E);
    send(3'b100, 1'b1, 16'h0000, 4'h0, 8'h00, 16'h0002, 2'b00);
    expDec(6'b000100, NOMOD);
    wr(16'h0514, 16'h00E0);
    send(3'b100, 1'b1, 16'h0000, 4'h1, 8'h00, 16'h0002, 2'b10);
    expDec(6'b110010, 6'h3F);
    wr(16'h0514, 16'h0080);
    rd(16'h0514, 16'h0080);
    check({15'h0000, bridgeMode_q}, 16'h0000);
    $display("test modes done");
    for (int k = 0; k < 3; k++) begin
      wr(16'h0514, 16'h0040 | (16'h0020 >> k));
      send(3'b100 >> k, 1'b1, 16'h0140, 4'hB, 8'h00, 16'h0003, 2'b00);
      expDec(6'b110001, 6'h3F);
      wr(16'h0514, 16'h0078 & ~(16'h0020 >> k));
      send(3'b100 >> k, 1'b1, 16'h0140, 4'hB, 8'h00, 16'h0003, 2'b00);
      expDec(6'b000100, NOMOD);
    end
    $display("test detection done");
    wr(16'h0514, 16'h0078);
    send(3'b010, 1'b0, 16'h013F, 4'h0, 8'h00, 16'h0004, 2'b00);
    expDec(6'b100110, NOMOD);
    send(3'b001, 1'b0, 16'h0140, 4'hB, 8'h00, 16'h0004, 2'b00);
    expDec(6'b100100, NOMOD);
    send(3'b010, 1'b0, 16'h0141, 4'h0, 8'h00, 16'h0004, 2'b00);
    expDec(6'b000100, NOMOD);
    wr(16'h0516, 16'h0000);
    send(3'b010, 1'b0, 16'h013F, 4'h0, 8'h00, 16'h0004, 2'b00);
    expDec(6'b000100, NOMOD);
    $display("test unicast done");
    for (int k = 0; k < 2; k++) begin
      send(3'b100, 1'b1, 16'h0000, k[3:0], 8'h00, 16'h0005, 2'b01);
      expDec(6'b100010, NOMOD);
      send(3'b100, 1'b1, 16'h0000, k[3:0], 8'h05, 16'h0005, 2'b01);
      expDec(6'b101010, NOMOD);
    end
    wr(16'h0516, 16'h0800);
    send(3'b100, 1'b1, 16'h0000, 4'h1, 8'h00, 16'h0005, 2'b01);
    expDec(6'b101010, NOMOD);
    $display("test alternate done");
    sinkMode <= 2'd1;
    wr(16'h0516, 16'h0400);
    send(3'b100, 1'b1, 16'h0000, 4'hB, 8'h00, 16'h0006, 2'b00);
    expDec(6'b110010, NOMOD);
    wr(16'h0516, 16'h0200);
    send(3'b100, 1'b1, 16'h0000, 4'h0, 8'h00, 16'h0016, 2'b00);
    expDec(6'b110010, NOMOD);
    send(3'b100, 1'b1, 16'h0000, 4'h8, 8'h00, 16'h0016, 2'b00);
    expDec(6'b110000, NOMOD);
    send(3'b100, 1'b1, 16'h0000, 4'h8, 8'h00, 16'h0017, 2'b00);
    expDec(6'b100000, NOMOD);
    $display("test priority done");
    @(posedge mclk);
    sinkMode <= 2'd2;
    send(3'b100, 1'b1, 16'h0000, 4'hB, 8'h00, 16'h0008, 2'b00);
    wr(16'h0514, 16'h0000);
    send(3'b100, 1'b1, 16'h0000, 4'hB, 8'h00, 16'h0008, 2'b00);
    send(3'b100, 1'b1, 16'h0000, 4'hB, 8'h00, 16'h0008, 2'b00);
    repeat (3) @(negedge mclk);
    check({15'h0000, descReady_q}, 16'h0000);
    @(posedge mclk);
    sinkMode <= 2'd0;
    expDec(6'b110000, NOMOD);
    expDec(6'b000100, NOMOD);
    expDec(6'b000100, NOMOD);
    $display("test stall done");
    complete_run();
  end
endmodule // ptp_message_config_bench
